// ===== logic/sasc_flag_if.sv
// Purpose: carries set, clear and held flags between the register file and a flag bank
// Assumes: one clock, driven by the owner of the flag bank
// Notes:   width is a parameter
`timescale 1ns/1ns
`default_nettype none
interface sasc_flag_if #(parameter int unsigned W = 32);
  logic [W-1:0] set_bits;
  logic [W-1:0] clr_bits;
  logic [W-1:0] flags;
  // flag bank side
  modport owner (input set_bits, input clr_bits, output flags);
  // register file side
  modport user (output set_bits, output clr_bits, input flags);
endinterface // sasc_flag_if
`default_nettype wire

// ===== logic/sasc_pkg.sv
// Purpose: shared constants for the port status, error and control register set
// Assumes: 32-bit register bus, byte addresses, one aligned word per register
// Notes:   all offsets, field positions, codes and reset values live here
`default_nettype none
package sasc_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_ERROR  = 4'h4;
  localparam logic [3:0] REG_CTRL   = 4'h8;
  localparam logic [3:0] REG_IMASK  = 4'hc;

  // status field positions
  localparam int unsigned ST_PWR_LSB = 8;
  localparam int unsigned ST_SPD_LSB = 4;
  localparam int unsigned ST_DET_LSB = 0;
  localparam int unsigned ST_W       = 12;

  // power state codes
  localparam logic [3:0] PWR_NONE    = 4'h0;
  localparam logic [3:0] PWR_ACTIVE  = 4'h1;
  localparam logic [3:0] PWR_PARTIAL = 4'h2;
  localparam logic [3:0] PWR_SLUMBER = 4'h6;

  // speed codes
  localparam logic [3:0] SPD_NONE = 4'h0;
  localparam logic [3:0] SPD_GEN1 = 4'h1;
  localparam logic [3:0] SPD_GEN2 = 4'h2;

  // presence and phy codes
  localparam logic [3:0] DET_NONE    = 4'h0;
  localparam logic [3:0] DET_PRESENT = 4'h1;
  localparam logic [3:0] DET_LINK    = 4'h3;
  localparam logic [3:0] DET_OFFLINE = 4'h4;

  // error flag register layout
  localparam logic [31:0] ERR_RESET      = 32'h0040_0000;
  localparam logic [31:0] ERR_VALID      = 32'h0fff_0f03;
  localparam int unsigned ERR_BIT_PHYRDY = 16;
  localparam int unsigned ERR_BIT_EXCHG  = 26;

  // control register layout
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0004;
  localparam logic [31:0] CTRL_WMASK   = 32'h001f_ffff;
  localparam int unsigned CTRL_SPM_LSB = 12;
  localparam int unsigned CTRL_PWR_LSB = 8;
  localparam int unsigned CTRL_SPD_LSB = 4;
  localparam int unsigned CTRL_DET_LSB = 0;

  // interrupt mask reset
  localparam logic [31:0] IMASK_RESET = 32'h0000_0000;

  // bus handshake states
  typedef enum logic {SASC_BUS_IDLE, SASC_BUS_ACK} sasc_bus_t;

endpackage
`default_nettype wire

// ===== logic/sasc_regs.sv
// Purpose: per-port link status, sticky error flags and control register set
// Assumes: Avalon-MM slave with waitrequest, 250 MHz clk_in, sync active-low reset
// Notes:   every request is answered one cycle after it is first seen
//
// Functional notes
// - writing one clears a flag bit, writing zero leaves it alone
// - power field bits 11:8 reports none 0, active 1, partial 2, slumber 6
// - speed field bits 7:4 reports none 0, first rate 1, second rate 2
// - presence field bits 3:0 reports none, present, linked, or offline code
// - control reserved bits read zero after reset; software writes zeros there
// - error flags accumulate since last clear and hold until cleared or reset
// - control register reads back the value last written, with only bits 20:0 kept
`timescale 1ns/1ns
`default_nettype none
module sasc_regs
  import sasc_pkg::*;
(
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_b_in,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [3:0]        avs_byteenable_in,
  input  wire logic [DATA_W-1:0] avs_writedata_in,
  output logic [DATA_W-1:0]      avs_readdata_out,
  output logic                   avs_waitrequest_out,
  // link conditions from phy and link layers
  input  wire logic              dev_present_in,
  input  wire logic              phy_comm_in,
  input  wire logic              loopback_in,
  input  wire logic              gen2_in,
  input  wire logic              partial_in,
  input  wire logic              slumber_in,
  // error events, one-cycle pulses
  input  wire logic [31:0]       err_event_in,
  // control fields
  output logic [3:0]             select_power_request_out,
  output logic [3:0]             ctrl_power_out,
  output logic [3:0]             ctrl_speed_out,
  output logic [3:0]             ctrl_presence_out,
  // interrupt
  output logic                   irq_out
);

  // bus handshake state
  sasc_bus_t         bus_state_r;
  sasc_bus_t         bus_state_nxt;
  logic              waitreq_r;
  logic              waitreq_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  // register state
  logic [31:0]       ctrl_r;
  logic [31:0]       ctrl_nxt;
  logic [31:0]       imask_r;
  logic [31:0]       imask_nxt;
  logic              irq_r;
  logic              irq_nxt;

  // link change tracking
  logic              present_prev_r;
  logic              present_prev_nxt;
  logic              comm_prev_r;
  logic              comm_prev_nxt;

  // decode helpers
  logic [31:0]       be_mask;
  logic              wr_take;
  logic              offline;
  logic [31:0]       status_word;
  logic [31:0]       err_set;
  logic [ST_W-1:0]   status_code;

  sasc_flag_if #(.W(32)) err_if ();

  // expand byte enables to a bit mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      be_mask[i*8 +: 8] = {8{avs_byteenable_in[i]}};
    end
  end

  // a write lands only on the edge where waitrequest is seen low
  assign wr_take = avs_write_in && (bus_state_r == SASC_BUS_ACK);

  // disabled port or loopback forces the offline code
  assign offline = loopback_in || (ctrl_r[CTRL_DET_LSB +: 4] == DET_OFFLINE);

  // status encoder
  sasc_status_enc u_status (
    .clk_in         (clk_in),
    .rst_b_in       (rst_b_in),
    .dev_present_in (dev_present_in),
    .phy_comm_in    (phy_comm_in),
    .offline_in     (offline),
    .gen2_in        (gen2_in),
    .partial_in     (partial_in),
    .slumber_in     (slumber_in),
    .status_out     (status_code)
  );

  // upper status bits stay zero
  assign status_word = {{(32 - ST_W){1'b0}}, status_code};

  // error events plus phy-ready and presence changes
  always_comb begin
    err_set                 = err_event_in;
    err_set[ERR_BIT_PHYRDY] = err_event_in[ERR_BIT_PHYRDY] ||
                              (phy_comm_in != comm_prev_r);
    err_set[ERR_BIT_EXCHG]  = err_event_in[ERR_BIT_EXCHG] ||
                              (dev_present_in != present_prev_r);
  end

  assign err_if.set_bits = err_set;
  assign err_if.clr_bits = (wr_take && avs_address_in == REG_ERROR) ?
                           (avs_writedata_in & be_mask) : 32'h0000_0000;

  // sticky error flags
  sasc_w1c_flags #(
    .W     (32),
    .RESET (ERR_RESET),
    .VALID (ERR_VALID)
  ) u_err (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .fl       (err_if.owner)
  );

  // link change history
  always_comb begin
    present_prev_nxt = dev_present_in;
    comm_prev_nxt    = phy_comm_in;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      present_prev_r <= 1'b0;
      comm_prev_r    <= 1'b0;
    end else begin
      present_prev_r <= present_prev_nxt;
      comm_prev_r    <= comm_prev_nxt;
    end
  end

  // control and mask writes
  always_comb begin
    ctrl_nxt  = ctrl_r;
    imask_nxt = imask_r;
    if (wr_take && avs_address_in == REG_CTRL) begin
      ctrl_nxt = ((ctrl_r & ~be_mask) | (avs_writedata_in & be_mask))
                 & CTRL_WMASK;
    end
    if (wr_take && avs_address_in == REG_IMASK) begin
      imask_nxt = ((imask_r & ~be_mask) | (avs_writedata_in & be_mask))
                  & ERR_VALID;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ctrl_r  <= CTRL_RESET;
      imask_r <= IMASK_RESET;
    end else begin
      ctrl_r  <= ctrl_nxt;
      imask_r <= imask_nxt;
    end
  end

  // level interrupt from unmasked flags
  always_comb begin
    irq_nxt = |(err_if.flags & imask_r);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // bus handshake and read mux
  always_comb begin
    bus_state_nxt = bus_state_r;
    waitreq_nxt   = waitreq_r;
    rdata_nxt     = rdata_r;
    unique case (bus_state_r)
      SASC_BUS_IDLE: begin
        waitreq_nxt = 1'b1;
        if (avs_read_in || avs_write_in) begin
          bus_state_nxt = SASC_BUS_ACK;
          waitreq_nxt   = 1'b0;
          unique case (avs_address_in)
            REG_STATUS: rdata_nxt = status_word;
            REG_ERROR:  rdata_nxt = err_if.flags;
            REG_CTRL:   rdata_nxt = ctrl_r;
            REG_IMASK:  rdata_nxt = imask_r;
            default:    rdata_nxt = 32'h0000_0000; // unmapped reads zero
          endcase
        end
      end
      SASC_BUS_ACK: begin
        bus_state_nxt = SASC_BUS_IDLE;
        waitreq_nxt   = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      bus_state_r <= SASC_BUS_IDLE;
      waitreq_r   <= 1'b1;
      rdata_r     <= 32'h0000_0000;
    end else begin
      bus_state_r <= bus_state_nxt;
      waitreq_r   <= waitreq_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  // outputs straight from flops
  assign avs_readdata_out         = rdata_r;
  assign avs_waitrequest_out      = waitreq_r;
  assign select_power_request_out = ctrl_r[CTRL_SPM_LSB +: 4];
  assign ctrl_power_out           = ctrl_r[CTRL_PWR_LSB +: 4];
  assign ctrl_speed_out           = ctrl_r[CTRL_SPD_LSB +: 4];
  assign ctrl_presence_out        = ctrl_r[CTRL_DET_LSB +: 4];
  assign irq_out                  = irq_r;

endmodule // sasc_regs
`default_nettype wire

// ===== logic/sasc_status_enc.sv
// Purpose: encodes link conditions into power, speed and presence codes
// Assumes: condition inputs are already on clk_in
// Notes:   result is registered, one cycle behind the inputs
`timescale 1ns/1ns
`default_nettype none
module sasc_status_enc
  import sasc_pkg::*;
(
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_b_in,
  // link conditions
  input  wire logic              dev_present_in,
  input  wire logic              phy_comm_in,
  input  wire logic              offline_in,
  input  wire logic              gen2_in,
  input  wire logic              partial_in,
  input  wire logic              slumber_in,
  // encoded status
  output logic [ST_W-1:0]        status_out
);

  logic [ST_W-1:0] status_r;
  logic [ST_W-1:0] status_nxt;
  logic [3:0]      pwr;
  logic [3:0]      link_speed_code;
  logic [3:0]      presence_phy_state;
  logic            link_up;

  // pick the three codes
  always_comb begin
    link_up = dev_present_in && phy_comm_in && !offline_in;
    if (!link_up) begin
      pwr = PWR_NONE;
    end else if (slumber_in) begin
      pwr = PWR_SLUMBER;
    end else if (partial_in) begin
      pwr = PWR_PARTIAL;
    end else begin
      pwr = PWR_ACTIVE;
    end
    if (!link_up) begin
      link_speed_code = SPD_NONE;
    end else begin
      link_speed_code = gen2_in ? SPD_GEN2 : SPD_GEN1;
    end
    if (offline_in) begin
      presence_phy_state = DET_OFFLINE;
    end else if (!dev_present_in) begin
      presence_phy_state = DET_NONE;
    end else if (!phy_comm_in) begin
      presence_phy_state = DET_PRESENT;
    end else begin
      presence_phy_state = DET_LINK;
    end
    status_nxt = {pwr, link_speed_code, presence_phy_state};
  end

  // register the codes
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign status_out = status_r;

endmodule // sasc_status_enc
`default_nettype wire

// ===== logic/sasc_w1c_flags.sv
// Purpose: bank of sticky flags, set by events, cleared by writing ones
// Assumes: set and clear arrive as one-cycle pulses on clk_in
// Notes:   a set in the same cycle as its clear leaves the flag set
`timescale 1ns/1ns
`default_nettype none
module sasc_w1c_flags #(
  parameter int unsigned     W     = 32,
  parameter logic [W-1:0]    RESET = '0,
  parameter logic [W-1:0]    VALID = '1
) (
  // clock and reset
  input  wire logic          clk_in,
  input  wire logic          rst_b_in,
  // flag traffic
  sasc_flag_if.owner         fl
);

  logic [W-1:0] flags_r;
  logic [W-1:0] flags_nxt;

  // accumulate events, clear on ones, set beats clear
  always_comb begin
    flags_nxt = ((flags_r & ~fl.clr_bits) | fl.set_bits) & VALID;
  end

  // hold flags until cleared or reset
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      flags_r <= RESET & VALID;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign fl.flags = flags_r;

endmodule // sasc_w1c_flags
`default_nettype wire

// ===== sim/sasc_drive_model.sv
// Purpose: far-side drive, presents link condition levels
// Assumes: mode word set by the bench, applied one edge later
// Notes:   bits {loop,slumber,partial,gen2,comm,present}
`timescale 1ns/1ns
`default_nettype none
module sasc_drive_model (
  // clock and command
  input  wire logic       clk_in,
  input  wire logic [5:0] mode_in,
  // link levels
  output logic            dev_present_out,
  output logic            phy_comm_out,
  output logic            gen2_out,
  output logic            partial_out,
  output logic            slumber_out,
  output logic            loopback_out
);
  // levels change only on a clock edge, like a synced phy
  always_ff @(posedge clk_in) begin
    {loopback_out, slumber_out, partial_out, gen2_out, phy_comm_out, dev_present_out}
      <= mode_in;
  end
endmodule // sasc_drive_model
`default_nettype wire

// ===== sim/sasc_regs_chk.sv
// Purpose: port-level assertions for the register set
// Assumes: one clock, sync active-low reset
// Notes:   bound to every sasc_regs instance
`timescale 1ns/1ns
`default_nettype none
module sasc_regs_chk
  import sasc_pkg::*;
(
  // clock, reset, bus
  input wire logic              clk_in,
  input wire logic              rst_b_in,
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic              avs_read_in,
  input wire logic              avs_write_in,
  input wire logic [3:0]        avs_byteenable_in,
  input wire logic [DATA_W-1:0] avs_writedata_in,
  input wire logic [DATA_W-1:0] avs_readdata_out,
  input wire logic              avs_waitrequest_out,
  // link side and outputs
  input wire logic              loopback_in,
  input wire logic [3:0]        select_power_request_out,
  input wire logic [3:0]        ctrl_power_out,
  input wire logic [3:0]        ctrl_speed_out,
  input wire logic [3:0]        ctrl_presence_out,
  input wire logic              irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  wire logic rd_ok = avs_read_in && !avs_waitrequest_out;
  wire logic [15:0] ctl = {select_power_request_out, ctrl_power_out,
                           ctrl_speed_out, ctrl_presence_out};
  // bus handshake shape
  a_wait_one_cycle: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("request not answered next cycle");
  a_wait_pulse_only: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low too long");
  a_wait_idle_high: assert property (!avs_read_in && !avs_write_in |=> avs_waitrequest_out)
    else $error("answer without request");
  // read data contents
  a_status_top_zero: assert property (rd_ok && avs_address_in == REG_STATUS
    |-> avs_readdata_out[31:12] == 20'h00000) else $error("status top bits set");
  a_status_offline: assert property (rd_ok && avs_address_in == REG_STATUS
    && $past(loopback_in, 2) |-> avs_readdata_out[11:0] == {8'h00, DET_OFFLINE})
    else $error("loopback not offline");
  a_unmapped_zero: assert property (rd_ok && avs_address_in[1:0] != 2'h0
    |-> avs_readdata_out == 32'h00000000) else $error("unmapped read not zero");
  // control outputs
  a_ctrl_write_lands: assert property (avs_write_in && !avs_waitrequest_out
    && avs_address_in == REG_CTRL && avs_byteenable_in == 4'hf
    |=> ctl == $past(avs_writedata_in[15:0])) else $error("control write lost");
  a_ctrl_reset_val: assert property ($rose(rst_b_in) |-> ctl == 16'h0004 && !irq_out)
    else $error("control reset value wrong");
endmodule // sasc_regs_chk
bind sasc_regs sasc_regs_chk u_chk (
  .clk_in                   (clk_in),
  .rst_b_in                 (rst_b_in),
  .avs_address_in           (avs_address_in),
  .avs_read_in              (avs_read_in),
  .avs_write_in             (avs_write_in),
  .avs_byteenable_in        (avs_byteenable_in),
  .avs_writedata_in         (avs_writedata_in),
  .avs_readdata_out         (avs_readdata_out),
  .avs_waitrequest_out      (avs_waitrequest_out),
  .loopback_in              (loopback_in),
  .select_power_request_out (select_power_request_out),
  .ctrl_power_out           (ctrl_power_out),
  .ctrl_speed_out           (ctrl_speed_out),
  .ctrl_presence_out        (ctrl_presence_out),
  .irq_out                  (irq_out)
);
`default_nettype wire

// ===== sim/sasc_regs_test.sv
// Purpose: self-checking bench for the register set
// Assumes: drive model on link inputs, bus answers in its own time
// Notes:   random modes and data from a fixed seed
`timescale 1ns/1ns
`default_nettype none
module sasc_regs_test;
  import sasc_pkg::*;
  logic clk_in = 0, rst_b_in = 0, rd = 0, wr = 0;
  logic [3:0] adr = 4'h0, be = 4'hf;
  logic [31:0] wd = 32'h0, rdata, ev = 32'h0, e1, e2, d, q;
  logic [5:0] mode = 6'h00;
  logic pres, comm, g2, part, slum, loopb, wait_r, irq;
  logic [3:0] select_power_request, pwr, link_speed_code, presence_phy_state;
  int errors = 0, checks = 0;
  // clock
  initial begin
    forever #2 clk_in = ~clk_in;
  end
  sasc_drive_model u_drv (.clk_in(clk_in), .mode_in(mode), .dev_present_out(pres),
    .phy_comm_out(comm), .gen2_out(g2), .partial_out(part), .slumber_out(slum),
    .loopback_out(loopb));
  sasc_regs DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_byteenable_in(be), .avs_writedata_in(wd),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_r), .dev_present_in(pres),
    .phy_comm_in(comm), .loopback_in(loopb), .gen2_in(g2), .partial_in(part),
    .slumber_in(slum), .err_event_in(ev), .select_power_request_out(select_power_request),
    .ctrl_power_out(pwr), .ctrl_speed_out(link_speed_code), .ctrl_presence_out(presence_phy_state), .irq_out(irq));
  // verdict and end of run
  task close_out;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] v, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk_in);
    adr <= a;
    wd <= v;
    be <= b;
    rd <= !w;
    wr <= w;
    // sample waitrequest and read data at the rising edge only
    do begin
      @(posedge clk_in);
      n++;
    end while (wait_r !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wait_r !== 1'b0) begin
      errors++;
      close_out();
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task pulse(input logic [31:0] v);
    @(posedge clk_in);
    ev <= v;
    @(posedge clk_in);
    ev <= 32'h0;
  endtask
  // expected status word from drive mode and control presence field
  function automatic logic [31:0] exp_st(input logic [5:0] m, input logic [3:0] cd);
    logic [3:0] p;
    if (m[5] || cd == DET_OFFLINE) return {28'h0, DET_OFFLINE};
    if (!m[0]) return 32'h0;
    if (!m[1]) return {28'h0, DET_PRESENT};
    p = m[4] ? PWR_SLUMBER : (m[3] ? PWR_PARTIAL : PWR_ACTIVE);
    return {20'h0, p, m[2] ? SPD_GEN2 : SPD_GEN1, DET_LINK};
  endfunction
  // watchdog
  initial begin
    #200000;
    errors++;
    close_out();
  end
  initial begin
    q = $urandom(32'hcb56a845);
    cyc(5);
    rst_b_in <= 1'b1;
    bus(0, REG_CTRL, 0, 4'hf); chk(q, CTRL_RESET);
    bus(0, REG_STATUS, 0, 4'hf); chk(q, exp_st(6'h00, 4'h4));
    bus(0, REG_ERROR, 0, 4'hf); chk(q, ERR_RESET);
    bus(0, 4'h3, 0, 4'hf); chk(q, 32'h0);
    bus(1, REG_STATUS, 32'hffffffff, 4'hf);
    bus(0, REG_STATUS, 0, 4'hf); chk(q, 32'h4);
    // control write and readback, then a single byte lane
    repeat (6) begin
      d = $urandom & 32'h0000_ffff;
      bus(1, REG_CTRL, d, 4'hf);
      bus(0, REG_CTRL, 0, 4'hf); chk(q, d & CTRL_WMASK);
      chk({select_power_request, pwr, link_speed_code, presence_phy_state}, d[15:0]);
    end
    bus(1, REG_CTRL, 32'h000000ff, 4'h1);
    bus(0, REG_CTRL, 0, 4'hf); chk(q, (d & CTRL_WMASK) | 32'hff);
    bus(1, REG_CTRL, 32'h0, 4'hf);
    // status encodings over random link modes
    repeat (12) begin
      mode <= 6'($urandom);
      cyc(4);
      bus(0, REG_STATUS, 0, 4'hf); chk(q, exp_st(mode, 4'h0));
    end
    mode <= 6'h03;
    cyc(4);
    // sticky flags: clear, accumulate, partial clear, zero write
    bus(1, REG_ERROR, 32'hffffffff, 4'hf);
    bus(0, REG_ERROR, 0, 4'hf); chk(q, 32'h0);
    e1 = $urandom & ERR_VALID & ~32'h1; // keeps bit 0 of e2 alive for the irq test
    e2 = ($urandom & ERR_VALID) | 32'h1;
    pulse(e1);
    pulse(e2);
    cyc(2);
    bus(0, REG_ERROR, 0, 4'hf); chk(q, e1 | e2);
    bus(1, REG_ERROR, e1, 4'hf);
    bus(1, REG_ERROR, 32'h0, 4'hf);
    bus(0, REG_ERROR, 0, 4'hf); chk(q, e2 & ~e1);
    // interrupt: masked, unmasked, cleared
    cyc(3); chk(irq, 1'b0);
    bus(1, REG_IMASK, ERR_VALID, 4'hf);
    bus(0, REG_IMASK, 0, 4'hf); chk(q, ERR_VALID);
    cyc(3); chk(irq, 1'b1);
    bus(1, REG_ERROR, 32'hffffffff, 4'hf);
    cyc(3); chk(irq, 1'b0);
    // reset in mid-run restores defaults
    mode <= 6'h00;
    bus(1, REG_CTRL, 32'h00001230, 4'hf);
    cyc(3);
    rst_b_in <= 1'b0;
    cyc(2);
    rst_b_in <= 1'b1;
    bus(0, REG_CTRL, 0, 4'hf); chk(q, CTRL_RESET);
    bus(0, REG_ERROR, 0, 4'hf); chk(q, ERR_RESET);
    bus(0, REG_IMASK, 0, 4'hf); chk(q, IMASK_RESET);
    chk({select_power_request, pwr, link_speed_code, presence_phy_state}, CTRL_RESET[15:0]);
    chk(irq, 1'b0);
    close_out();
  end
endmodule // sasc_regs_test
`default_nettype wire
